//--- verilog/rmw_pkg.sv
package rmw_pkg;

    // ----------------------------------------
    // Bus encodings
    // ----------------------------------------
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] TT_ACK    = 2'h3;

    // ----------------------------------------
    // Sequence constants
    // ----------------------------------------
    localparam int          IDLE_CLKS   = 1;
    localparam logic [31:0] SEM_SET_BIT = 32'h0000_0080;
    localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

    // ----------------------------------------
    // Operations and states
    // ----------------------------------------
    typedef enum logic [1:0] {
        OP_TEST_AND_SET,
        OP_COMPARE_AND_SWAP,
        OP_COMPARE_AND_SWAP_DUAL,
        OP_TABLE_UPDATE
    } rmw_op_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH,
        ST_RD_ADDR,
        ST_RD_DATA,
        ST_GAP,
        ST_WR_ADDR,
        ST_WR_DATA
    } seq_state_e;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        rmw_op_e     op;
        logic [31:0] addr0;
        logic [31:0] addr1;
        logic [1:0]  size;
        logic [1:0]  tt;
        logic [2:0]  tm;
        logic [1:0]  upa;
        logic        cache_hit;
        logic        cache_dirty;
        logic [31:0] cmp0;
        logic [31:0] cmp1;
        logic [31:0] upd0;
        logic [31:0] upd1;
    } rmw_req_s;

    typedef struct packed {
        logic        refused;
        logic        matched;
        logic [31:0] read0;
        logic [31:0] read1;
    } rmw_resp_s;

endpackage

//--- verilog/rmw_lane_steer.sv
`timescale 1ns/1ps
module rmw_lane_steer
    import rmw_pkg::*;
(
    // Transfer shape
    input  wire logic [1:0]  size,
    input  wire logic [1:0]  low_addr,
    // Data, operand side right-justified
    input  wire logic [31:0] op_wdata,
    input  wire logic [31:0] bus_rdata,
    output logic      [31:0] bus_wdata,
    output logic      [31:0] op_rdata
);

    // ----------------------------------------
    // Lane placement, big-endian byte order
    // ----------------------------------------
    function automatic logic [4:0] lane_shift(input logic [1:0] sz, input logic [1:0] a);
        logic [2:0] nbytes;
        nbytes = (sz == SIZE_BYTE) ? 3'd1 : (sz == SIZE_WORD) ? 3'd2 : 3'd4;
        lane_shift = {3'(3'd4 - nbytes - {1'b0, a}), 2'b00} << 1;
    endfunction

    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        size_mask = (sz == SIZE_BYTE) ? 32'h0000_00FF :
                    (sz == SIZE_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    endfunction

    logic [4:0] shift;

    // Lanes above the selected ones carry the operand's stale bits and lanes below them are zero; the slave ignores both
    always_comb begin
        shift     = lane_shift(size, low_addr);
        bus_wdata = op_wdata << shift;
        op_rdata  = (bus_rdata >> shift) & size_mask(size);
    end

endmodule

//--- verilog/locked_rmw_bus_sequencer.sv
`timescale 1ns/1ps
module locked_rmw_bus_sequencer
    import rmw_pkg::*;
#(
    parameter int GAP_CLKS = IDLE_CLKS
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Core request and answer
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire rmw_req_s    req,
    output rmw_resp_s        resp,
    output logic             resp_valid,
    // Data cache
    output logic             cache_invalidate,
    output logic             cache_push_req,
    input  wire logic        cache_push_done,
    // External bus, active-low controls
    output logic      [31:0] address,
    output logic      [1:0]  transfer_type,
    output logic      [2:0]  transfer_modifier,
    output logic      [1:0]  user_page_attr,
    output logic             transfer_size_hi,
    output logic             transfer_size_lo,
    output logic             read_write,
    output logic             cache_inhibit_out_n,
    output logic             transfer_start_n,
    output logic             transfer_in_progress_n,
    output logic             bus_lock_n,
    output logic             lock_end_n,
    input  wire logic        transfer_ack_n,
    // Data bus, three signals
    input  wire logic [31:0] data_in,
    output logic      [31:0] data_out,
    output logic             data_oe_n
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    seq_state_e  state;
    rmw_req_s    cur;
    logic        rd_idx;
    logic        wr_idx;
    logic [31:0] rd0;
    logic [31:0] rd1;
    logic [7:0]  gap_cnt;
    logic        ack;
    logic        take;
    logic        chain;
    logic        wr_last;
    logic [31:0] wr_addr;
    logic [31:0] wr_val;
    logic        match0;
    logic        match1;
    logic [31:0] lane_wdata;
    logic [31:0] lane_rdata;
    logic [31:0] bus_addr;

    assign ack = !transfer_ack_n;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] size_mask(input logic [1:0] sz);
        size_mask = (sz == SIZE_BYTE) ? 32'h0000_00FF :
                    (sz == SIZE_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    endfunction

    function automatic logic acceptable(input rmw_req_s r);
        acceptable = (r.tt != TT_ACK);
    endfunction

    // ----------------------------------------
    // Request acceptance
    // ----------------------------------------
    // A new request is taken when idle, or at the very end of the final write so that
    // back-to-back locked sequences keep lock without a gap, and in-progress too unless the next one first waits for a cache push.
    always_comb begin
        chain     = (state == ST_WR_DATA) && ack && wr_last;
        req_ready = (state == ST_IDLE) || (chain && acceptable(req));
        take      = req_valid && req_ready;
    end

    // ----------------------------------------
    // Write plan
    // ----------------------------------------
    always_comb begin
        match0  = ((rd0 ^ cur.cmp0) & size_mask(cur.size)) == DATA_ZERO;
        match1  = ((rd1 ^ cur.cmp1) & size_mask(cur.size)) == DATA_ZERO;
        wr_last = 1'b1;
        wr_addr = cur.addr0;
        wr_val  = rd0;
        case (cur.op)
            OP_TEST_AND_SET: begin
                wr_val = rd0 | SEM_SET_BIT;
            end
            OP_COMPARE_AND_SWAP: begin
                wr_val = match0 ? cur.upd0 : rd0;
            end
            OP_COMPARE_AND_SWAP_DUAL: begin
                if (match0 && match1) begin
                    wr_last = wr_idx;
                    wr_addr = wr_idx ? cur.addr1 : cur.addr0;
                    wr_val  = wr_idx ? cur.upd1 : cur.upd0;
                end else begin
                    wr_addr = cur.addr1;
                    wr_val  = rd1;
                end
            end
            OP_TABLE_UPDATE: begin
                wr_val = rd0 | cur.upd0;
            end
            default: begin
                wr_val = rd0;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state  <= ST_IDLE;
            rd_idx <= 1'b0;
            wr_idx <= 1'b0;
        end else begin
            case (state)
                ST_IDLE, ST_WR_DATA: begin
                    if (state == ST_WR_DATA && !ack) begin
                        state <= ST_WR_DATA;
                    end else if (state == ST_WR_DATA && !wr_last) begin
                        state  <= ST_WR_ADDR;
                        wr_idx <= 1'b1;
                    end else if (take && acceptable(req)) begin
                        rd_idx <= 1'b0;
                        wr_idx <= 1'b0;
                        if (req.cache_hit && req.cache_dirty) begin
                            state <= ST_PUSH;
                        end else begin
                            state <= ST_RD_ADDR;
                        end
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_PUSH: begin
                    if (cache_push_done) begin
                        state <= ST_RD_ADDR;
                    end
                end
                ST_RD_ADDR: begin
                    state <= ST_RD_DATA;
                end
                ST_RD_DATA: begin
                    if (ack) begin
                        if (cur.op == OP_COMPARE_AND_SWAP_DUAL && !rd_idx) begin
                            state  <= ST_RD_ADDR;
                            rd_idx <= 1'b1;
                        end else begin
                            state <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    if (gap_cnt >= 8'(GAP_CLKS - 1)) begin
                        state <= ST_WR_ADDR;
                    end
                end
                ST_WR_ADDR: begin
                    state <= ST_WR_DATA;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Idle clock counter; the compare settles here
    always_ff @(posedge clk) begin
        if (rst || state != ST_GAP) begin
            gap_cnt <= 8'h00;
        end else begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Request capture and read data
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
            rd0 <= DATA_ZERO;
            rd1 <= DATA_ZERO;
        end else begin
            if (take && acceptable(req)) begin
                cur <= req;
            end
            if (state == ST_RD_DATA && ack) begin
                if (rd_idx) begin
                    rd1 <= lane_rdata;
                end else begin
                    rd0 <= lane_rdata;
                end
            end
        end
    end

    // ----------------------------------------
    // Cache side and answer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cache_invalidate <= 1'b0;
            cache_push_req   <= 1'b0;
            resp_valid       <= 1'b0;
            resp             <= '0;
        end else begin
            cache_invalidate <= take && acceptable(req) && req.cache_hit;
            cache_push_req   <= take && acceptable(req) && req.cache_hit && req.cache_dirty;
            resp_valid       <= (take && !acceptable(req)) || chain;
            if (take && !acceptable(req)) begin
                resp <= '{refused: 1'b1, matched: 1'b0, read0: DATA_ZERO, read1: DATA_ZERO};
            end else if (chain) begin
                resp.refused <= 1'b0;
                resp.matched <= (cur.op == OP_COMPARE_AND_SWAP_DUAL) ? (match0 && match1) : match0;
                resp.read0   <= rd0;
                resp.read1   <= rd1;
            end
        end
    end

    // ----------------------------------------
    // Bus address and data registers
    // ----------------------------------------
    // Address is loaded one clock ahead so it stands from a flop in each address clock.
    always_comb begin
        bus_addr = address;
        if (state == ST_RD_DATA && ack && cur.op == OP_COMPARE_AND_SWAP_DUAL && !rd_idx) begin
            bus_addr = cur.addr1;
        end else if (take && acceptable(req)) begin
            bus_addr = req.addr0;
        end else if (state == ST_GAP || (state == ST_WR_DATA && ack && !wr_last)) begin
            bus_addr = (state == ST_GAP) ? wr_addr :
                       (cur.op == OP_COMPARE_AND_SWAP_DUAL) ? cur.addr1 : wr_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            address  <= 32'h0000_0000;
            data_out <= DATA_ZERO;
        end else begin
            address <= bus_addr;
            if (state == ST_WR_ADDR) begin
                data_out <= lane_wdata;
            end
        end
    end

    rmw_lane_steer u_lanes (
        .size      (cur.size),
        .low_addr  (address[1:0]),
        .op_wdata  (wr_val),
        .bus_rdata (data_in),
        .bus_wdata (lane_wdata),
        .op_rdata  (lane_rdata)
    );

    // ----------------------------------------
    // Bus controls, decoded from state flops
    // ----------------------------------------
    always_comb begin
        transfer_type          = cur.tt;
        transfer_modifier      = cur.tm;
        user_page_attr         = cur.upa;
        transfer_size_hi       = cur.size[1];
        transfer_size_lo       = cur.size[0];
        transfer_start_n       = 1'b1;
        transfer_in_progress_n = 1'b1;
        bus_lock_n             = 1'b1;
        lock_end_n             = 1'b1;
        read_write             = 1'b1;
        cache_inhibit_out_n    = 1'b1;
        data_oe_n              = 1'b1;
        case (state)
            ST_PUSH: begin
                bus_lock_n = 1'b0;
            end
            ST_RD_ADDR, ST_RD_DATA: begin
                bus_lock_n             = 1'b0;
                transfer_in_progress_n = 1'b0;
                cache_inhibit_out_n    = 1'b0;
                transfer_start_n       = (state != ST_RD_ADDR);
            end
            ST_GAP: begin
                bus_lock_n = 1'b0;
            end
            ST_WR_ADDR, ST_WR_DATA: begin
                bus_lock_n             = 1'b0;
                transfer_in_progress_n = 1'b0;
                cache_inhibit_out_n    = 1'b0;
                read_write             = 1'b0;
                transfer_start_n       = (state != ST_WR_ADDR);
                lock_end_n             = !wr_last;
                data_oe_n              = (state != ST_WR_DATA);
            end
            default: begin
                bus_lock_n = 1'b1;
            end
        endcase
    end

endmodule

//--- testbench/locked_rmw_checker_sva.sv
`timescale 1ns/1ps
module locked_rmw_checker
    import rmw_pkg::*;
#(
    parameter int GAP_CLKS = IDLE_CLKS
)(
    // Clock and reset
    input wire logic      clk,
    input wire logic      rst,
    // Core side
    input wire logic      req_valid,
    input wire logic      req_ready,
    input wire rmw_req_s  req,
    input wire rmw_resp_s resp,
    input wire logic      resp_valid,
    input wire logic      cache_invalidate,
    // Bus side
    input wire logic [31:0] address,
    input wire logic [1:0]  transfer_type,
    input wire logic [2:0]  transfer_modifier,
    input wire logic [1:0]  user_page_attr,
    input wire logic      read_write,
    input wire logic      cache_inhibit_out_n,
    input wire logic      transfer_start_n,
    input wire logic      transfer_in_progress_n,
    input wire logic      bus_lock_n,
    input wire logic      lock_end_n,
    input wire logic      transfer_ack_n,
    input wire logic      data_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wire logic take = req_valid && req_ready;

    AST_START_ONE_CLK: assert property ($fell(transfer_start_n) |=> transfer_start_n)
        else $error("start held over one clock");
    AST_READ_START: assert property (!transfer_start_n && read_write |->
        !bus_lock_n && !transfer_in_progress_n && !cache_inhibit_out_n && lock_end_n)
        else $error("read start without its companions");
    AST_WRITE_START: assert property (!transfer_start_n && !read_write |->
        !transfer_in_progress_n && !bus_lock_n && data_oe_n)
        else $error("write start without its companions");
    AST_LOCK_END_WRITE: assert property (!lock_end_n |-> !read_write && !bus_lock_n)
        else $error("lock end outside a locked write");
    AST_DATA_WINDOW: assert property (!data_oe_n |-> !read_write && transfer_start_n)
        else $error("data bus driven outside write data clocks");
    AST_WRITE_END: assert property (!data_oe_n && !transfer_ack_n |=> data_oe_n)
        else $error("data bus still driven after write ack");
    AST_LOCK_END_DROP: assert property (!lock_end_n && !data_oe_n && !transfer_ack_n |=> lock_end_n)
        else $error("lock end kept after final write");
    AST_INPROG_READ_END: assert property ($rose(transfer_in_progress_n) && !bus_lock_n |->
        read_write && !$past(transfer_ack_n))
        else $error("in-progress dropped mid-lock without read ack");
    AST_GAP_TO_WRITE: assert property ($rose(transfer_in_progress_n) && !bus_lock_n |->
        ##GAP_CLKS (!transfer_start_n && !read_write))
        else $error("write address clock not after the idle gap");
    AST_LOCK_RELEASE: assert property ($rose(bus_lock_n) |->
        !$past(transfer_ack_n) && !$past(data_oe_n))
        else $error("lock released before a write ack");
    AST_REFUSED: assert property (take && req.tt == TT_ACK |=>
        resp_valid && resp.refused && transfer_start_n)
        else $error("acknowledge type not refused");
    AST_INVALIDATE: assert property (take && req.cache_hit && req.tt != TT_ACK |=> cache_invalidate)
        else $error("cache hit not invalidated");
    AST_ATTR_HOLD: assert property (!transfer_in_progress_n && transfer_start_n |->
        $stable({address, transfer_type, transfer_modifier, user_page_attr}))
        else $error("address or attributes moved within a transfer");

    cover property (take && req.op == OP_COMPARE_AND_SWAP_DUAL);
    cover property (!data_oe_n && transfer_ack_n);
    cover property (take && !transfer_ack_n);
endmodule

bind locked_rmw_bus_sequencer locked_rmw_checker #(.GAP_CLKS(GAP_CLKS)) u_chk (.*);

//--- testbench/rmw_bus_slave.sv
`timescale 1ns/1ps
module rmw_bus_slave
    import rmw_pkg::*;
(
    // Clock and wait setting
    input wire logic        clk,
    input wire logic [3:0]  waits,
    // Bus from the sequencer
    input wire logic [31:0] address,
    input wire logic        transfer_size_hi,
    input wire logic        transfer_size_lo,
    input wire logic        read_write,
    input wire logic        transfer_start_n,
    input wire logic        bus_lock_n,
    input wire logic        lock_end_n,
    input wire logic [31:0] data_out,
    // Answer
    output logic            transfer_ack_n,
    output logic [31:0]     data_in
);
    logic [31:0] mem [16];
    logic [31:0] a_q;
    logic [31:0] m;
    logic [3:0]  cnt;
    logic        busy = 1'b0;
    logic        tog = 1'b0;
    logic        lock_q = 1'b1;
    logic        rw_q;
    logic [1:0]  sz_q;
    int          n_rd = 0;
    int          n_wr = 0;
    int          n_le = 0;
    int          n_unlk = 0;

    // Big-endian lanes: the byte at offset 0 rides bits 31:24
    always_comb begin
        case (sz_q)
            SIZE_BYTE: m = 32'hFF00_0000 >> (8 * a_q[1:0]);
            SIZE_WORD: m = a_q[1] ? 32'h0000_FFFF : 32'hFFFF_0000;
            default:   m = 32'hFFFF_FFFF;
        endcase
    end

    // Unselected lanes and idle bus toggle so stale data can never pass for a read
    assign transfer_ack_n = !(busy && cnt == 4'h0);
    assign data_in = (!transfer_ack_n && rw_q) ? (mem[a_q[5:2]] & m) | ({32{tog}} & ~m)
                                               : {32{tog}} ^ 32'h5A5A_5A5A;

    always @(posedge clk) begin
        tog <= !tog;
        lock_q <= bus_lock_n;
        // Arbiter view: a lock release is where grants may resume
        if (bus_lock_n && !lock_q) n_unlk++;
        if (!transfer_start_n) begin
            busy <= 1'b1;
            cnt <= waits;
            a_q <= address;
            rw_q <= read_write;
            sz_q <= {transfer_size_hi, transfer_size_lo};
            if (read_write) n_rd++;
            else n_wr++;
            if (!lock_end_n) n_le++;
        end else if (busy) begin
            if (cnt == 4'h0) begin
                busy <= 1'b0;
                if (!rw_q) mem[a_q[5:2]] <= (mem[a_q[5:2]] & ~m) | (data_out & m);
            end else begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

//--- testbench/locked_rmw_bus_sequencer_tb_top.sv
`timescale 1ns/1ps
module locked_rmw_bus_sequencer_tb_top import rmw_pkg::*;;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        req_valid = 1'b0;
    logic        cache_push_done = 1'b0;
    logic [3:0]  waits = 4'h0;
    rmw_req_s    req = '0;
    rmw_resp_s   resp;
    logic        req_ready, resp_valid, cache_invalidate, cache_push_req;
    logic [31:0] address, data_in, data_out;
    logic [1:0]  transfer_type, user_page_attr;
    logic [2:0]  transfer_modifier;
    logic        transfer_size_hi, transfer_size_lo, read_write, cache_inhibit_out_n, transfer_start_n;
    logic        transfer_in_progress_n, bus_lock_n, lock_end_n, transfer_ack_n, data_oe_n;
    int          miscompares = 0;
    int          n_tests = 0;

    locked_rmw_bus_sequencer DUT (.*);
    rmw_bus_slave mdl (.*);

    always #5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h, expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic hung(input string what);
        miscompares++;
        $display("[FAIL] %0t no %s in time", $time, what);
        conclude();
    endtask

    task automatic wait_ready;
        for (int i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge clk);
        if (req_ready !== 1'b1) hung("ready");
    endtask

    task automatic wait_resp;
        for (int i = 0; i < 400 && resp_valid !== 1'b1; i++) @(negedge clk);
        if (resp_valid !== 1'b1) hung("answer");
    endtask

    task automatic issue(input rmw_req_s r);
        req = r;
        req_valid = 1'b1;
        wait_ready();
        @(negedge clk);
        req_valid = 1'b0;
    endtask

    task automatic counts(input int rd, input int wr, input int le);
        check(32'(mdl.n_rd), 32'(rd), "read transfers");
        check(32'(mdl.n_wr), 32'(wr), "write transfers");
        check(32'(mdl.n_le), 32'(le), "lock end marks");
        mdl.n_rd = 0;
        mdl.n_wr = 0;
        mdl.n_le = 0;
        mdl.n_unlk = 0;
    endtask

    function automatic rmw_req_s mk(input rmw_op_e op, input logic [31:0] a0, input logic [31:0] a1,
                                    input logic [1:0] sz, input logic [31:0] c0, input logic [31:0] c1,
                                    input logic [31:0] u0, input logic [31:0] u1);
        mk = '{op: op, addr0: a0, addr1: a1, size: sz, tt: 2'h0, tm: 3'h1, upa: 2'h2, cache_hit: 1'b0,
               cache_dirty: 1'b0, cmp0: c0, cmp1: c1, upd0: u0, upd1: u1};
    endfunction

    task automatic t_set_and_table;
        mdl.mem[4] = 32'hA5A5_A512;
        mdl.mem[3] = 32'h0000_0100;
        issue(mk(OP_TEST_AND_SET, 32'h13, '0, SIZE_BYTE, '0, '0, '0, '0));
        check(address, 32'h0000_0013, "read address");
        check(32'({transfer_type, transfer_modifier, user_page_attr, transfer_start_n, read_write,
                   cache_inhibit_out_n, transfer_size_hi, transfer_size_lo}), 32'h0C9, "read address clock");
        wait_resp();
        check(resp.read0, 32'h12, "set read lane");
        check(mdl.mem[4], 32'hA5A5_A592, "set write lane");
        counts(1, 1, 1);
        issue(mk(OP_TABLE_UPDATE, 32'hC, '0, SIZE_LONG, '0, '0, 32'h8, '0));
        wait_resp();
        check(mdl.mem[3], 32'h0000_0108, "table update");
        counts(1, 1, 1);
    endtask

    task automatic t_cas;
        waits = 4'h2;
        for (int hit = 1; hit >= 0; hit--) begin
            mdl.mem[8] = 32'h1234_5678;
            issue(mk(OP_COMPARE_AND_SWAP, 32'h20, '0, SIZE_LONG, hit ? 32'h1234_5678 : 32'h1234_0000, '0,
                     32'hCAFE_F00D, '0));
            wait_resp();
            check(32'(resp.matched), 32'(hit), "swap match");
            check(mdl.mem[8], hit ? 32'hCAFE_F00D : 32'h1234_5678, "swap write");
            counts(1, 1, 1);
        end
        waits = 4'h0;
    endtask

    task automatic t_cas_dual;
        for (int ok = 1; ok >= 0; ok--) begin
            mdl.mem[1] = 32'h11;
            mdl.mem[2] = 32'h22;
            issue(mk(OP_COMPARE_AND_SWAP_DUAL, 32'h4, 32'h8, SIZE_LONG, 32'h11, ok ? 32'h22 : 32'h33,
                     32'hAA, 32'hBB));
            wait_resp();
            check(resp.read1, 32'h22, "dual second read");
            check(mdl.mem[1], ok ? 32'hAA : 32'h11, "dual first word");
            check(mdl.mem[2], ok ? 32'hBB : 32'h22, "dual second word");
            counts(2, ok ? 2 : 1, 1);
        end
    endtask

    task automatic t_refused_and_push;
        rmw_req_s r;
        int       starts = 0;
        r = mk(OP_COMPARE_AND_SWAP, 32'h20, '0, SIZE_LONG, '0, '0, '0, '0);
        r.tt = TT_ACK;
        issue(r);
        wait_resp();
        check(32'(resp.refused), 32'h1, "acknowledge refused");
        counts(0, 0, 0);
        @(negedge clk);
        r.tt = 2'h0;
        r.cache_hit = 1'b1;
        r.cache_dirty = 1'b1;
        issue(r);
        check(32'({cache_invalidate, cache_push_req}), 32'h3, "cache pulses");
        // Push held off for a while: the locked read must not start early
        repeat (6) begin
            @(negedge clk);
            starts += (transfer_start_n !== 1'b1);
        end
        check(32'(starts), 32'h0, "start before push done");
        cache_push_done = 1'b1;
        @(negedge clk);
        cache_push_done = 1'b0;
        wait_resp();
        counts(1, 1, 1);
    endtask

    task automatic t_chain;
        // Let the previous release be counted before the lock tally starts
        @(negedge clk);
        mdl.n_unlk = 0;
        mdl.mem[8] = 32'h0;
        mdl.mem[4] = 32'h0;
        req = mk(OP_COMPARE_AND_SWAP, 32'h20, '0, SIZE_LONG, '0, '0, 32'h5, '0);
        req_valid = 1'b1;
        wait_ready();
        @(negedge clk);
        req = mk(OP_TEST_AND_SET, 32'h13, '0, SIZE_BYTE, '0, '0, '0, '0);
        wait_ready();
        @(negedge clk);
        req_valid = 1'b0;
        wait_resp();
        check(mdl.mem[8], 32'h5, "first of chain");
        @(negedge clk);
        wait_resp();
        check(mdl.mem[4], 32'h80, "second of chain");
        @(negedge clk);
        check(32'(mdl.n_unlk), 32'h1, "lock kept across chain");
        counts(2, 2, 2);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(32'({req_ready, transfer_start_n, transfer_in_progress_n, bus_lock_n, lock_end_n,
                   data_oe_n, resp_valid}), 32'h7E, "idle outputs");
        t_set_and_table();
        t_cas();
        t_cas_dual();
        t_refused_and_push();
        t_chain();
        conclude();
    end
endmodule
